/* File: logic/dcr_ctrl_regs.sv */
/*
 * Control register bank for a dual voice codec, addresses 3 to 7, reached
 * over the two-wire control port (open-drain data, host-driven clock).
 * Assumes scl, sda and the address straps are synchronous to ref_clk and
 * that ref_clk is fast enough to see every control-port level.
 */
// Functional notes
// R1 - Addresses 3 to 7 decode to five eight-bit control registers.
// R2 - Bit 7 of address 3 reports codec 1 ADC overflow.
// R3 - Address 3 bits 6:1 set ADC gain; 110000 mutes; 12 to -36 dB.
// R4 - Gain code 100001 is maximum, each step down 1.5 dB, 000001 minimum.
// R5 - ADC codes 011001 and 000000 both give unity gain.
// R6 - Address 3 bit 0 routes codec 1 to the line output.
// R7 - Address 4 bits 7:6 ignored; bits 5:0 DAC gain, same code map.
// R8 - DAC codes 011001 and 000000 both give unity gain.
// R9 - Address 5 bits 7:3 select handset, headset, mic, line, caller-ID in.
// R10 - Address 5 bits 2:0 select handset, headset, speaker outputs.
// R11 - Address 5 resets to 0x84: handset in, handset out.
// R12 - Address 6 bits 7:4 hold D divisor minus one.
// R13 - Address 6 bits 3:0 hold N as plain binary.
// R14 - Address 6 resets to 0x50.
// R15 - Address 7 bits 7:4 hold I minus one.
// R16 - Address 7 bit 3 enables codec 2 analog loopback.
// R17 - Address 7 bit 2 enables codec 2 digital loopback.
// R18 - Address 7 bit 1 powers codec 2 down.
// R19 - Writing one to address 7 bit 0 resets codec 2 control state.
// R20 - Address 7 resets to 0x50.
// R21 - Codec 1 software reset restores addresses 3 to 5 to defaults.
// R22 - Port address is 11100 then the two strap bits.
// R23 - Overflow bit is read-only; writes keep it unchanged.
`timescale 1ns/1ps
module dcr_ctrl_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control port pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [1:0] addrStrap,
   // Codec events
   input wire logic adcOverflow,
   input wire logic codec1SwReset,
   // Codec controls
   output dcr_pkg::dcr_c1_ctrl_t c1Ctrl,
   output dcr_pkg::dcr_c2_ctrl_t c2Ctrl,
   output dcr_pkg::dcr_gain_t adcGain,
   output dcr_pkg::dcr_gain_t dacGain,
   output logic codec2SwResetPulse
);
   import dcr_pkg::*;

   dcr_regs_state_t s;
   dcr_regs_state_t n;
   logic startCond;
   logic stopCond;
   logic sclRise;
   logic sclFall;
   logic wrStb;
   logic rdLoad;
   logic [7:0] rdByte;

   // ************************************************************
   // Read mux
   // ************************************************************
   function automatic logic [7:0] read_byte(input dcr_regs_state_t r);
      logic [7:0] v;
      v = UNMAPPED_RD;                                // R1
      if (r.ptr == REG_ADC1) begin
         v = {r.ovf, r.adcField};
      end else if (r.ptr == REG_DAC1) begin
         v = {2'h0, r.dacGain};                       // R7
      end else if (r.ptr == REG_ROUTE1) begin
         v = r.route;
      end else if (r.ptr == REG_RATE2) begin
         v = r.rate2;
      end else if (r.ptr == REG_CTRL2) begin
         v = r.ctrl2;
      end
      return v;
   endfunction

   assign rdByte = read_byte(s);
   assign startCond = s.sclPrev && sclIn && s.sdaPrev && !sdaIn;
   assign stopCond = s.sclPrev && sclIn && !s.sdaPrev && sdaIn;
   assign sclRise = !s.sclPrev && sclIn;
   assign sclFall = s.sclPrev && !sclIn;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      n = s;
      n.sclPrev = sclIn;
      n.sdaPrev = sdaIn;
      n.swRst2 = 1'b0;
      wrStb = 1'b0;
      rdLoad = 1'b0;
      if (startCond) begin
         // Repeated start keeps the pointer for read-after-write
         n.st = ST_ADDR;
         n.bitCnt = 4'h0;
         n.sdaOe = 1'b0;
      end else if (stopCond) begin
         n.st = ST_IDLE;
         n.sdaOe = 1'b0;
      end else if (sclRise) begin
         if (s.st == ST_ADDR || s.st == ST_PTR || s.st == ST_WDATA) begin
            n.shift = {s.shift[6:0], sdaIn};
            n.bitCnt = s.bitCnt + 4'h1;
         end else if (s.st == ST_RDATA) begin
            n.bitCnt = s.bitCnt + 4'h1;
         end else if (s.st == ST_RACK) begin
            // Host not acking ends the read burst
            if (sdaIn) begin
               n.st = ST_IDLE;
            end else begin
               n.ptr = s.ptr + 8'h01;
            end
         end
      end else if (sclFall) begin
         unique case (s.st)
            ST_ADDR: begin
               if (s.bitCnt == BYTE_BITS) begin
                  if (s.shift[7:1] == {I2C_ADDR_HI, addrStrap}) begin
                     n.st = ST_AACK;                  // R22
                     n.rw = s.shift[0];
                     n.sdaOe = 1'b1;
                  end else begin
                     n.st = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (s.rw) begin
                  rdLoad = 1'b1;
               end else begin
                  n.st = ST_PTR;
                  n.sdaOe = 1'b0;
                  n.bitCnt = 4'h0;
               end
            end
            ST_PTR: begin
               if (s.bitCnt == BYTE_BITS) begin
                  n.ptr = s.shift;
                  n.st = ST_PACK;
                  n.sdaOe = 1'b1;
               end
            end
            ST_PACK: begin
               n.st = ST_WDATA;
               n.sdaOe = 1'b0;
               n.bitCnt = 4'h0;
            end
            ST_WDATA: begin
               if (s.bitCnt == BYTE_BITS) begin
                  wrStb = 1'b1;
                  n.st = ST_WACK;
                  n.sdaOe = 1'b1;
               end
            end
            ST_WACK: begin
               // Burst writes walk up through the map
               n.st = ST_WDATA;
               n.sdaOe = 1'b0;
               n.bitCnt = 4'h0;
               n.ptr = s.ptr + 8'h01;
            end
            ST_RDATA: begin
               if (s.bitCnt == BYTE_BITS) begin
                  n.st = ST_RACK;
                  n.sdaOe = 1'b0;
               end else begin
                  n.shift = {s.shift[6:0], 1'b0};
                  n.sdaOe = !s.shift[6];
               end
            end
            ST_RACK: begin
               rdLoad = 1'b1;
            end
            default: begin
               n.st = ST_IDLE;
            end
         endcase
      end
      if (rdLoad) begin
         n.shift = rdByte;
         n.sdaOe = !rdByte[7];
         n.bitCnt = 4'h0;
         n.st = ST_RDATA;
      end
      if (wrStb) begin
         if (s.ptr == REG_ADC1) begin
            n.adcField = s.shift[6:0];                // R23
         end else if (s.ptr == REG_DAC1) begin
            n.dacGain = s.shift[5:0];                 // R7
         end else if (s.ptr == REG_ROUTE1) begin
            n.route = s.shift;                        // R9 R10
         end else if (s.ptr == REG_RATE2) begin
            n.rate2 = s.shift;                        // R12 R13
         end else if (s.ptr == REG_CTRL2) begin
            if (s.shift[SWRST_BIT]) begin
               n.rate2 = RATE2_RST;                   // R19
               n.ctrl2 = CTRL2_RST;
               n.swRst2 = 1'b1;
            end else begin
               n.ctrl2 = s.shift;                     // R15 R16 R17 R18
            end
         end
      end
      if (codec1SwReset) begin
         n.adcField = ADC1_RST[6:0];                  // R21
         n.dacGain = DAC1_RST[5:0];
         n.route = ROUTE1_RST;
         n.ovf = 1'b0;
      end
      // Reading the overflow flag clears it
      if (rdLoad && s.ptr == REG_ADC1) begin
         n.ovf = 1'b0;
      end
      // Set wins over any clear in the same cycle
      if (adcOverflow) begin
         n.ovf = 1'b1;                                // R2
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= REGS_RST;                               // R11 R14 R20
      end else begin
         s <= n;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Open drain: the pin is only ever pulled low
   assign sdaOut = 1'b0;
   assign sdaOe = s.sdaOe;
   assign c1Ctrl = {s.route, s.adcField[LINE_OUT_BIT], s.adcField[6:1],
      s.dacGain};                                     // R6 R9 R10
   assign c2Ctrl = {s.rate2, s.ctrl2[7:1]};           // R16 R17 R18
   assign codec2SwResetPulse = s.swRst2;

   logic [5:0] gainCodes [2];
   dcr_gain_t gainOut [2];
   assign gainCodes[0] = s.adcField[6:1];
   assign gainCodes[1] = s.dacGain;

   generate
      for (genvar g = 0; g < 2; g++) begin : g_gain
         dcr_gain_decode #(
            .CODE_W(GAIN_CODE_W)
         ) u_dec (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .gainCode(gainCodes[g]),
            .gain(gainOut[g])
         );
      end
   endgenerate

   assign adcGain = gainOut[0];                       // R3
   assign dacGain = gainOut[1];                       // R7

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   property p_reset_vals;
      $rose(rst_n) |-> s.route == ROUTE1_RST && s.rate2 == RATE2_RST
         && s.ctrl2 == CTRL2_RST && !s.sdaOe;
   endproperty
   a_reset_vals: assert property (p_reset_vals) // R11 R14 R20
      else $error("register reset values wrong");

   property p_unmapped;
      wrStb && (s.ptr < REG_ADC1 || s.ptr > REG_CTRL2) && !codec1SwReset
      |=> $stable(s.route) && $stable(s.rate2) && $stable(s.ctrl2)
         && $stable(s.adcField) && $stable(s.dacGain);
   endproperty
   a_unmapped: assert property (p_unmapped) // R1
      else $error("unmapped write changed a register");

   property p_ovf_set;
      adcOverflow |=> s.ovf ##1 (rdByte[OVF_BIT] || s.ptr != REG_ADC1
         || !s.ovf || !$stable(s.ovf));
   endproperty
   a_ovf_set: assert property (p_ovf_set) // R2
      else $error("overflow not flagged");

   property p_adc_wr;
      wrStb && s.ptr == REG_ADC1 && !codec1SwReset
      |=> c1Ctrl.lineOutputSelect == $past(s.shift[0])
         && c1Ctrl.adcGainCode == $past(s.shift[6:1]);
   endproperty
   a_adc_wr: assert property (p_adc_wr) // R6 R3
      else $error("ADC gain write not applied");

   property p_ovf_ro;
      wrStb && s.ptr == REG_ADC1 && !adcOverflow && !codec1SwReset
      |=> s.ovf == $past(s.ovf);
   endproperty
   a_ovf_ro: assert property (p_ovf_ro) // R23
      else $error("write altered overflow flag");

   property p_dac_wr;
      wrStb && s.ptr == REG_DAC1 && !codec1SwReset
      |=> c1Ctrl.dacGainCode == $past(s.shift[5:0]) ##1
         dacGain.mute == (c1Ctrl.dacGainCode == GAIN_MUTE
            || c1Ctrl.dacGainCode > GAIN_MAX);
   endproperty
   a_dac_wr: assert property (p_dac_wr) // R7
      else $error("DAC gain write or mute wrong");

   property p_route_wr;
      wrStb && s.ptr == REG_ROUTE1 && !codec1SwReset
      |=> c1Ctrl[20:13] == $past(s.shift);
   endproperty
   a_route_wr: assert property (p_route_wr) // R9 R10
      else $error("routing write not applied");

   property p_c2_wr;
      wrStb && s.ptr >= REG_RATE2 && s.ptr <= REG_CTRL2 && !s.shift[0]
      |=> c2Ctrl == ($past(s.ptr) == REG_RATE2
         ? {$past(s.shift), $past(c2Ctrl[6:0])}
         : {$past(c2Ctrl[14:7]), $past(s.shift[7:1])});
   endproperty
   a_c2_wr: assert property (p_c2_wr) // R12 R13 R15 R16 R17 R18
      else $error("codec 2 write not applied");

   property p_swrst2;
      wrStb && s.ptr == REG_CTRL2 && s.shift[SWRST_BIT]
      |=> codec2SwResetPulse && s.rate2 == RATE2_RST
         && s.ctrl2 == CTRL2_RST ##1 !codec2SwResetPulse;
   endproperty
   a_swrst2: assert property (p_swrst2) // R19
      else $error("codec 2 software reset wrong");

   property p_c1rst;
      codec1SwReset |=> s.route == ROUTE1_RST
         && s.adcField == ADC1_RST[6:0] && s.dacGain == DAC1_RST[5:0];
   endproperty
   a_c1rst: assert property (p_c1rst) // R21
      else $error("codec 1 software reset wrong");

   property p_addr_ack;
      s.st == ST_ADDR && sclFall && s.bitCnt == BYTE_BITS && !startCond
      |=> s.sdaOe == ($past(s.shift[7:1]) == {I2C_ADDR_HI,
         $past(addrStrap)});
   endproperty
   a_addr_ack: assert property (p_addr_ack) // R22
      else $error("address acknowledge wrong");

   c_write_route: cover property (wrStb && s.ptr == REG_ROUTE1);
   c_read_ack: cover property (s.st == ST_RACK && sclRise && !sdaIn);
   c_swrst2: cover property (codec2SwResetPulse);
   c_ovf_clear: cover property (rdLoad && s.ptr == REG_ADC1 && s.ovf);

endmodule // dcr_ctrl_regs

/* File: logic/dcr_pkg.sv */
/*
 * Shared constants and types for the dual codec control register bank:
 * register addresses, reset values, field positions, gain code points,
 * the control-port state machine encoding and the carrier structs.
 * Assumes a single control clock; nothing here holds logic.
 */
package dcr_pkg;

   // ************************************************************
   // Register addresses and reset values
   // ************************************************************
   localparam logic [7:0] REG_ADC1 = 8'h03;
   localparam logic [7:0] REG_DAC1 = 8'h04;
   localparam logic [7:0] REG_ROUTE1 = 8'h05;
   localparam logic [7:0] REG_RATE2 = 8'h06;
   localparam logic [7:0] REG_CTRL2 = 8'h07;
   localparam logic [7:0] ADC1_RST = 8'h00;
   localparam logic [7:0] DAC1_RST = 8'h00;
   localparam logic [7:0] ROUTE1_RST = 8'h84;
   localparam logic [7:0] RATE2_RST = 8'h50;
   localparam logic [7:0] CTRL2_RST = 8'h50;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int OVF_BIT = 7;
   localparam int LINE_OUT_BIT = 0;
   localparam int SWRST_BIT = 0;

   // ************************************************************
   // Gain code points and control-port address
   // ************************************************************
   localparam int GAIN_CODE_W = 6;
   localparam logic [5:0] GAIN_MUTE = 6'h30;
   localparam logic [5:0] GAIN_UNITY = 6'h19;
   localparam logic [5:0] GAIN_MAX = 6'h21;
   localparam logic [5:0] GAIN_ZERO = 6'h00;
   localparam logic [4:0] I2C_ADDR_HI = 5'h1C;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_AACK = 9'h004,
      ST_PTR = 9'h008,
      ST_PACK = 9'h010,
      ST_WDATA = 9'h020,
      ST_WACK = 9'h040,
      ST_RDATA = 9'h080,
      ST_RACK = 9'h100
   } dcr_port_st_t;

   typedef struct packed {
      logic mute;
      logic unity;
      logic signed [5:0] steps;
   } dcr_gain_t;

   localparam dcr_gain_t GAIN_RST = '{mute: 1'b0, unity: 1'b1,
      steps: 6'h00};

   typedef struct packed {
      logic handsetInputSelect;
      logic headsetInputSelect;
      logic microphoneInputSelect;
      logic lineInputSelect;
      logic callerIdInputSelect;
      logic handsetOutputSelect;
      logic headsetOutputSelect;
      logic speakerOutputSelect;
      logic lineOutputSelect;
      logic [5:0] adcGainCode;
      logic [5:0] dacGainCode;
   } dcr_c1_ctrl_t;

   typedef struct packed {
      logic [3:0] dDivisorM1;
      logic [3:0] nRate;
      logic [3:0] iRateM1;
      logic analogLoopback;
      logic digitalLoopback;
      logic powerDown;
   } dcr_c2_ctrl_t;

   typedef struct packed {
      dcr_port_st_t st;
      logic sclPrev;
      logic sdaPrev;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic rw;
      logic [7:0] ptr;
      logic sdaOe;
      logic ovf;
      logic [6:0] adcField;
      logic [5:0] dacGain;
      logic [7:0] route;
      logic [7:0] rate2;
      logic [7:0] ctrl2;
      logic swRst2;
   } dcr_regs_state_t;

   localparam dcr_regs_state_t REGS_RST = '{st: ST_IDLE, sclPrev: 1'b1,
      sdaPrev: 1'b1, shift: 8'h00, bitCnt: 4'h0, rw: 1'b0, ptr: 8'h00,
      sdaOe: 1'b0, ovf: 1'b0, adcField: ADC1_RST[6:0],
      dacGain: DAC1_RST[5:0], route: ROUTE1_RST, rate2: RATE2_RST,
      ctrl2: CTRL2_RST, swRst2: 1'b0};

endpackage

/* File: logic/dcr_gain_decode.sv */
/*
 * Registered decoder for one six-bit PGA gain code: mute, unity and the
 * signed gain in steps of 1.5 dB relative to unity.
 * Assumes the code comes from a register on the same clock.
 */
`timescale 1ns/1ps
module dcr_gain_decode #(
   parameter int CODE_W = 6
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Code in, decoded gain out
   input wire logic [CODE_W-1:0] gainCode,
   output dcr_pkg::dcr_gain_t gain
);
   import dcr_pkg::*;

   generate
      if (CODE_W != GAIN_CODE_W) begin : g_bad_width
         $error("gain code width must be six bits");
      end
   endgenerate

   dcr_gain_t s;
   dcr_gain_t n;

   always_comb begin
      n = '{mute: 1'b0, unity: 1'b0, steps: 6'h00};
      if (gainCode == GAIN_MUTE) begin
         n.mute = 1'b1;                               // R3
      end else if (gainCode == GAIN_ZERO || gainCode == GAIN_UNITY) begin
         n.unity = 1'b1;                              // R5 R8
      end else if (gainCode <= GAIN_MAX) begin
         n.steps = 6'(gainCode - GAIN_UNITY);         // R4
      end else begin
         // Undefined codes are muted rather than guessed at
         n.mute = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= GAIN_RST;
      end else begin
         s <= n;
      end
   end

   assign gain = s;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_gain_mute;
      @(posedge ref_clk) disable iff (!rst_n)
      gainCode == GAIN_MUTE |=> gain.mute && !gain.unity;
   endproperty
   a_gain_mute: assert property (p_gain_mute) // R3
      else $error("mute code did not mute");

   property p_gain_linear;
      @(posedge ref_clk) disable iff (!rst_n)
      (gainCode >= 6'h01 && gainCode <= GAIN_MAX && gainCode != GAIN_UNITY)
      |=> !gain.mute && gain.steps == 6'($past(gainCode) - GAIN_UNITY);
   endproperty
   a_gain_linear: assert property (p_gain_linear) // R4
      else $error("gain step not linear in code");

   property p_gain_unity;
      @(posedge ref_clk) disable iff (!rst_n)
      (gainCode == GAIN_ZERO || gainCode == GAIN_UNITY)
      |=> gain.unity && gain.steps == 6'h00 && !gain.mute;
   endproperty
   a_gain_unity: assert property (p_gain_unity) // R5 R8
      else $error("unity code did not give unity gain");

endmodule // dcr_gain_decode

/* File: testbench/dcr_host_model.sv */
/*
 * Host model for the two-wire control port: drives the port clock and
 * pulls the shared data line low; offers register write and read tasks.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/1ps
module dcr_host_model (
   // Clock
   input wire logic ref_clk,
   // Control port
   input wire logic sdaLine,
   input wire logic [1:0] strap,
   output logic sclOut,
   output logic sdaLow
);
   import dcr_pkg::*;

   // ************************************************************
   // Bus phases, each three ref_clk cycles long
   // ************************************************************
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic hold();
      repeat (3) @(negedge ref_clk);
   endtask

   // Sending one releases the line, so the same task also reads
   task automatic clk(input logic b, output logic v);
      sdaLow = !b;
      hold();
      sclOut = 1'b1;
      hold();
      v = sdaLine;
      sclOut = 1'b0;
      hold();
   endtask

   task automatic start();
      sdaLow = 1'b0;
      hold();
      sclOut = 1'b1;
      hold();
      sdaLow = 1'b1;
      hold();
      sclOut = 1'b0;
      hold();
   endtask

   task automatic stop();
      sdaLow = 1'b1;
      hold();
      sclOut = 1'b1;
      hold();
      sdaLow = 1'b0;
      hold();
   endtask

   task automatic putByte(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         clk(b[i], v);
      end
      clk(1'b1, v);
      ack = !v;
   endtask

   task automatic getByte(output logic [7:0] b, input logic last);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         clk(1'b1, b[i]);
      end
      clk(last, v);
   endtask

   task automatic writeReg(input logic [7:0] a, d, output logic ack);
      logic k;
      start();
      putByte({I2C_ADDR_HI, strap, 1'b0}, ack);
      putByte(a, k);
      putByte(d, k);
      stop();
   endtask

   task automatic readReg(input logic [7:0] a, output logic [7:0] d);
      logic k;
      start();
      putByte({I2C_ADDR_HI, strap, 1'b0}, k);
      putByte(a, k);
      start();
      putByte({I2C_ADDR_HI, strap, 1'b1}, k);
      getByte(d, 1'b1);
      stop();
   endtask
endmodule // dcr_host_model

/* File: testbench/dual_codec_control_registers_tb.sv */
/*
 * Self-checking bench for the codec control register bank.
 * Assumes the host model drives the port; the data line has a pull-up.
 */
`timescale 1ns/1ps
module dual_codec_control_registers_tb;
   import dcr_pkg::*;
   logic ref_clk, rst_n, adcOverflow, codec1SwReset, sdaOut, sdaOe;
   logic sclIn, hostLow, ack, codec2SwResetPulse;
   logic [1:0] addrStrap, hostStrap;
   wire logic sdaLine;
   dcr_c1_ctrl_t c1Ctrl;
   dcr_c2_ctrl_t c2Ctrl;
   dcr_gain_t adcGain, dacGain;
   int n_errors, comparisons, nPulse, cycles;

   // ************************************************************
   // Wiring
   // ************************************************************
   assign sdaLine = !(hostLow || (sdaOe && !sdaOut));

   dcr_ctrl_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclIn),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .addrStrap(addrStrap), .adcOverflow(adcOverflow),
      .codec1SwReset(codec1SwReset), .c1Ctrl(c1Ctrl), .c2Ctrl(c2Ctrl),
      .adcGain(adcGain), .dacGain(dacGain),
      .codec2SwResetPulse(codec2SwResetPulse));

   dcr_host_model host (.ref_clk(ref_clk), .sdaLine(sdaLine),
      .strap(hostStrap), .sclOut(sclIn), .sdaLow(hostLow));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (codec2SwResetPulse === 1'b1) nPulse++;
      cycles++;
      // Whole run needs about 12600 cycles
      if (cycles == 40000) begin
         n_errors++;
         give_verdict();
      end
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic give_verdict();
      if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [23:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      host.writeReg(a, d, ack);
   endtask

   task automatic rdChk(input logic [7:0] a, exp, input string nm);
      logic [7:0] d;
      host.readReg(a, d);
      chk(nm, d, exp);
   endtask

   function automatic dcr_gain_t gainOf(input logic [5:0] c);
      dcr_gain_t g;
      g.mute = 1'b0;
      g.unity = (c == 6'h00) || (c == 6'h19);
      g.steps = (c == 6'h00) ? 6'h00 : c - 6'h19;
      return g;
   endfunction

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      chk("route", c1Ctrl[20:13], 8'h84);
      chk("c2", c2Ctrl, {4'h5, 4'h0, 4'h5, 3'h0});
      chk("adcGain", adcGain, 8'h40);
      chk("sdaOut", sdaOut, 1'b0);
      rdChk(8'h05, 8'h84, "rd5");
      rdChk(8'h06, 8'h50, "rd6");
      rdChk(8'h07, 8'h50, "rd7");
      wr(8'h09, 8'hFF);
      rdChk(8'h09, 8'h00, "rd9");
   endtask

   task automatic t_gain();
      logic [5:0] codes [6] = '{6'h21, 6'h20, 6'h19, 6'h18, 6'h01, 6'h00};
      foreach (codes[i]) begin
         wr(8'h03, {1'b0, codes[i], 1'b1});
         wr(8'h04, {2'b11, codes[i]});
         chk("adcGain", adcGain, gainOf(codes[i]));
         chk("dacGain", dacGain, gainOf(codes[i]));
         chk("lineOut", c1Ctrl.lineOutputSelect, 1'b1);
         rdChk(8'h04, {2'b00, codes[i]}, "rd4");
      end
      wr(8'h03, 8'h60);
      wr(8'h04, 8'h30);
      chk("adcMute", adcGain.mute, 1'b1);
      chk("dacMute", dacGain.mute, 1'b1);
      chk("lineOut", c1Ctrl.lineOutputSelect, 1'b0);
   endtask

   task automatic t_ovf();
      @(negedge ref_clk) adcOverflow = 1'b1;
      @(negedge ref_clk) adcOverflow = 1'b0;
      rdChk(8'h03, 8'hE0, "ovfSet");
      rdChk(8'h03, 8'h60, "ovfClr");
      @(negedge ref_clk) adcOverflow = 1'b1;
      @(negedge ref_clk) adcOverflow = 1'b0;
      wr(8'h03, 8'h05);
      rdChk(8'h03, 8'h85, "ovfKeep");
   endtask

   task automatic t_codec2();
      int n;
      wr(8'h06, 8'hA7);
      chk("divisors", c2Ctrl[14:7], 8'hA7);
      wr(8'h07, 8'h3E);
      chk("ctrl2", c2Ctrl[6:0], {4'h3, 3'b111});
      rdChk(8'h07, 8'h3E, "rd7");
      wr(8'h07, 8'h24);
      chk("ctrl2", c2Ctrl[6:0], {4'h2, 3'b010});
      n = nPulse;
      wr(8'h07, 8'hFF);
      chk("swPulses", 24'(nPulse - n), 24'h000001);
      chk("c2", c2Ctrl, {4'h5, 4'h0, 4'h5, 3'h0});
      rdChk(8'h06, 8'h50, "rd6");
   endtask

   task automatic t_route_reset();
      wr(8'h05, 8'h7B);
      chk("route", c1Ctrl[20:13], 8'h7B);
      rdChk(8'h05, 8'h7B, "rd5");
      @(negedge ref_clk) codec1SwReset = 1'b1;
      @(negedge ref_clk) codec1SwReset = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("c1", c1Ctrl, {8'h84, 13'h0000});
   endtask

   task automatic t_addr();
      hostStrap = 2'b01;
      wr(8'h05, 8'h11);
      chk("nack", ack, 1'b0);
      chk("route", c1Ctrl[20:13], 8'h84);
      addrStrap = 2'b01;
      wr(8'h05, 8'h11);
      chk("ack", ack, 1'b1);
      chk("route", c1Ctrl[20:13], 8'h11);
   endtask

   // Burst write then burst read with host ack between bytes
   task automatic t_burst();
      logic [7:0] d0, d1;
      logic k;
      host.start();
      host.putByte({I2C_ADDR_HI, hostStrap, 1'b0}, k);
      host.putByte(8'h04, k);
      host.putByte(8'h15, k);
      host.putByte(8'h6A, k);
      host.start();
      host.putByte({I2C_ADDR_HI, hostStrap, 1'b0}, k);
      host.putByte(8'h04, k);
      host.start();
      host.putByte({I2C_ADDR_HI, hostStrap, 1'b1}, k);
      host.getByte(d0, 1'b0);
      host.getByte(d1, 1'b1);
      host.stop();
      chk("burst4", d0, 8'h15);
      chk("burst5", d1, 8'h6A);
      chk("route", c1Ctrl[20:13], 8'h6A);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      rst_n = 1'b0;
      adcOverflow = 1'b0;
      codec1SwReset = 1'b0;
      addrStrap = 2'b10;
      hostStrap = 2'b10;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      t_reset();
      t_gain();
      t_ovf();
      t_codec2();
      t_route_reset();
      t_addr();
      t_burst();
      give_verdict();
   end
endmodule // dual_codec_control_registers_tb
